// ==== rtl/flash_prog_pkg.sv ====
// Constants shared by the serial flash program/read sequencer and its FIFO.
// Assumes a single 250 MHz core clock; the serial link is oversampled by it.
package flash_prog_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 4;

  // Self-timed program durations (plain defaults, not device figures)
  localparam int PAGE_PROGRAM_TIME_NS = 8000;
  localparam int BYTE_PROGRAM_TIME_NS = 2000;

  // Least times, rounded up to whole cycles
  localparam int PAGE_PROGRAM_CYC = (PAGE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_PROGRAM_CYC = (BYTE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W          = 12;

  // Command opcodes
  localparam logic [7:0] OP_PROGRAM      = 8'h02;
  localparam logic [7:0] OP_DUAL_PROGRAM = 8'hA2;
  localparam logic [7:0] OP_DUAL_READ    = 8'h3B;

  // Array geometry
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam int          PAGE_BYTES  = 256;
  localparam logic [8:0]  PAGE_FULL   = 9'h100;
  localparam logic [7:0]  PAGE_LAST   = 8'hFF;
  localparam int          ARRAY_AW    = 22;
  localparam logic [21:0] ARRAY_TOP   = 22'h3FFFFF;
  localparam int          SECTOR_LSB  = 16;
  localparam int          SECTORS     = 64;
  localparam logic [1:0]  ADDR_LAST   = 2'h2;

  // Write FIFO between page buffer and array
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = ARRAY_AW + 8;

  // Serial command phase
  typedef enum logic [2:0] {
    ST_OPCODE = 3'h0,
    ST_ADDR   = 3'h1,
    ST_DUMMY  = 3'h2,
    ST_READ   = 3'h3,
    ST_DATA   = 3'h4,
    ST_IGNORE = 3'h5
  } link_state_t;

  // Internal program cycle
  typedef enum logic [1:0] {
    P_IDLE = 2'h0,
    P_SCAN = 2'h1,
    P_WAIT = 2'h2
  } prog_state_t;

endpackage

// ==== rtl/sync_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; storage is flip-flops.
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage words
  logic [AW:0]      wr_ptr_r;       // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_r;       // Read pointer with wrap bit
  logic             full;
  logic             empty;

  // Full when pointers differ only in the wrap bit
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  // Word storage, no reset needed
  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/flash_prog_seq.sv ====
// Serial flash command sequencer: byte/page program, dual-input program
// and dual-output array read, behind oversampled SPI pins (mode 0/3).
// Assumes serial clock well below a quarter of the core clock; array
// read data is valid one core cycle after read_addr changes.
//
// How it works
// R1: Read streams from address zero after top, no gap
// R2: Chip select high ends read, outputs tristated
// R3: Program accepted only with write enable latch set
// R4: Unsent page bytes stay erased, never written
// R5: Opcode 02h, three address bytes, data buffered
// R6: One to 256 data bytes per command
// R7: Data past page end wraps within page
// R8: Over 256 bytes keeps only last 256
// R9: Chip select rise programs buffer from start address
// R10: Self-timed, byte time for one byte, else page
// R11: Incomplete address, data or byte boundary aborts
// R12: Protected or locked sector is not programmed
// R13: Any abort clears write enable latch
// R14: Busy reported while programming
// R15: Write enable latch cleared before program completes
// R16: Failed byte sets program/erase error flag
// R17: Opcode A2h takes data two bits per clock
// R18: Host sends bit 7 on upper pin first
// R19: Opcode 3Bh, address, dummy, two bits out
// R20: Read address counter wraps top to zero
// R21: Busy held until cycle ends, then ready
`timescale 1ns/1ns
`default_nettype none
module flash_prog_seq
  import flash_prog_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                chip_select_n,
  input  wire logic                serial_clock,
  input  wire logic                serial_in,
  input  wire logic                dual_in_upper_pin_in,
  output logic                     dual_in_upper_pin_out,
  output logic                     dual_in_upper_pin_oe,
  output logic                     second_io_pin_out,
  output logic                     second_io_pin_oe,
  input  wire logic                write_enable_set,
  input  wire logic [SECTORS-1:0]  protect_map,
  input  wire logic [SECTORS-1:0]  lockdown_map,
  output logic      [ARRAY_AW-1:0] read_addr,
  input  wire logic [7:0]          read_data,
  output logic                     array_wr_valid,
  input  wire logic                array_wr_ready,
  output logic      [ARRAY_AW-1:0] array_wr_addr,
  output logic      [7:0]          array_wr_data,
  input  wire logic                program_fail,
  output logic                     write_enable_latch,
  output logic                     busy,
  output logic                     program_erase_error_flag
);

  // Pin synchronisers: {cs_n, sck, si, upper pin}
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic        sck_prev_r;          // Previous synced clock level
  logic        cs_prev_r;           // Previous synced select level
  logic        cs_hi;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;

  // Serial shifter
  link_state_t state_r;             // Command phase
  logic [2:0]  bit_cnt_r;           // Bits within current byte
  logic [2:0]  bit_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic        byte_done;           // Full byte just completed
  logic        dual_in;             // Two bits per clock
  logic        dual_r;              // Command is dual-input program
  logic        is_read_r;           // Command is dual-output read
  logic [1:0]  hdr_cnt_r;           // Address bytes seen
  logic [23:0] addr_r;              // Start address

  // Page buffer
  logic [7:0]  buf_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_r;    // Bytes that received data
  logic [7:0]  wptr_r;              // Buffer write index
  logic [8:0]  count_r;             // Data bytes, saturating at a page
  logic        data_start;
  logic        data_store;

  // Program control
  logic        wel_r;
  logic        busy_r;
  logic        err_r;
  logic        prog_cmd_active;
  logic        frame_ok;
  logic        prot;
  logic        prog_start;
  logic        prog_abort;
  prog_state_t prog_r;
  logic [7:0]  idx_r;               // Scan index over the page
  logic [ARRAY_AW-9:0] page_r;      // Page being programmed
  logic [TIMER_W-1:0]  timer_r;     // Remaining program time

  // FIFO and output stage
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic              advance;
  logic              wr_valid_r;
  logic [FIFO_W-1:0] wr_word_r;

  // Read output
  logic [ARRAY_AW-1:0] rd_addr_r;
  logic [1:0]          pair_r;      // Bit pair within output byte
  logic [7:0]          out_shift_r;
  logic                so_r;
  logic                sio_r;
  logic                oe_r;

  // Two-stage synchronisers, select idles high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_r    <= 4'h8;
      sync2_r    <= 4'h8;
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
    end else begin
      sync1_r    <= {chip_select_n, serial_clock, serial_in, dual_in_upper_pin_in};
      sync2_r    <= sync1_r;
      sck_prev_r <= sync2_r[2];
      cs_prev_r  <= sync2_r[3];
    end
  end

  // Edge detection only on the second stage
  assign cs_hi    = sync2_r[3];
  assign sck_rise = !cs_hi && sync2_r[2] && !sck_prev_r;
  assign sck_fall = !cs_hi && !sync2_r[2] && sck_prev_r;
  assign cs_rise  = cs_hi && !cs_prev_r;

  // Next shift value; dual data puts bit 7 on the upper pin
  always_comb begin
    dual_in   = (state_r == ST_DATA) && dual_r;
    bit_nxt   = dual_in ? bit_cnt_r + 3'h2 : bit_cnt_r + 3'h1; // R17
    shift_nxt = dual_in ? {shift_r[5:0], sync2_r[0], sync2_r[1]} // R18
                        : {shift_r[6:0], sync2_r[1]};
    byte_done = sck_rise && (bit_nxt == 3'h0);
  end

  // Bit counter and shifter; only the counter clears between frames
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
    end else if (cs_hi) begin
      bit_cnt_r <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_nxt;
      shift_r   <= shift_nxt;
    end
  end

  // Command phase sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= ST_OPCODE;
      hdr_cnt_r <= 2'h0;
      dual_r    <= 1'b0;
      is_read_r <= 1'b0;
      addr_r    <= 24'h000000;
    end else if (cs_hi) begin
      state_r   <= ST_OPCODE;
      hdr_cnt_r <= 2'h0;
    end else if (byte_done) begin
      unique case (state_r)
        ST_OPCODE: begin
          dual_r    <= (shift_nxt == OP_DUAL_PROGRAM);
          is_read_r <= (shift_nxt == OP_DUAL_READ);
          // Program needs the latch and an idle array
          if ((shift_nxt == OP_PROGRAM || shift_nxt == OP_DUAL_PROGRAM)
              && wel_r && !busy_r) begin
            state_r <= ST_ADDR; // R3 R5 R17
          end else if (shift_nxt == OP_DUAL_READ && !busy_r) begin
            state_r <= ST_ADDR; // R19
          end else begin
            state_r <= ST_IGNORE;
          end
        end
        ST_ADDR: begin
          addr_r    <= {addr_r[15:0], shift_nxt};
          hdr_cnt_r <= hdr_cnt_r + 2'h1;
          if (hdr_cnt_r == ADDR_LAST) begin
            state_r <= is_read_r ? ST_DUMMY : ST_DATA; // R19
          end
        end
        // Dummy byte discarded, output starts next falling edge
        ST_DUMMY: state_r <= ST_READ;
        // Data, read and ignore phases hold until select rises
        default:  state_r <= state_r;
      endcase
    end
  end

  assign data_start = byte_done && state_r == ST_ADDR && hdr_cnt_r == ADDR_LAST && !is_read_r;
  assign data_store = byte_done && state_r == ST_DATA;

  // Page buffer contents, preset erased at each program command
  always_ff @(posedge clock) begin
    if (data_start) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_r[i] <= ERASED_BYTE; // R4
      end
    end else if (data_store) begin
      buf_r[wptr_r] <= shift_nxt; // R5 R8
    end
  end

  // Buffer index, fill mask and byte count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wptr_r  <= 8'h00;
      count_r <= 9'h000;
      mask_r  <= '0;
    end else if (data_start) begin
      wptr_r  <= shift_nxt;
      count_r <= 9'h000;
      mask_r  <= '0;
    end else if (data_store) begin
      // Eight-bit index wraps inside the page; oldest bytes overwritten
      wptr_r         <= wptr_r + 8'h01; // R7 R8
      mask_r[wptr_r] <= 1'b1;
      if (count_r != PAGE_FULL) begin
        count_r <= count_r + 9'h001; // R6
      end
    end
  end

  // End-of-frame checks
  assign prog_cmd_active = (state_r == ST_ADDR && !is_read_r) || state_r == ST_DATA;
  assign frame_ok        = (bit_cnt_r == 3'h0) && (count_r != 9'h000); // R11
  assign prot            = protect_map[addr_r[ARRAY_AW-1:SECTOR_LSB]]
                         | lockdown_map[addr_r[ARRAY_AW-1:SECTOR_LSB]]; // R12
  assign prog_start      = cs_rise && state_r == ST_DATA && frame_ok && !prot; // R9
  assign prog_abort      = cs_rise && prog_cmd_active && !prog_start; // R11 R12

  // Write enable latch; device clears win over the host set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (prog_abort) begin
      wel_r <= 1'b0; // R13
    end else if (prog_start) begin
      wel_r <= 1'b0; // R15
    end else if (write_enable_set && !busy_r) begin
      wel_r <= 1'b1;
    end
  end

  // Program cycle: scan the page, push filled bytes, wait out the time
  assign fifo_in_valid = (prog_r == P_SCAN) && mask_r[idx_r]; // R4
  assign advance       = (prog_r == P_SCAN) && (!mask_r[idx_r] || fifo_in_ready);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_r <= P_IDLE;
      busy_r <= 1'b0;
      idx_r  <= 8'h00;
      page_r <= '0;
    end else begin
      unique case (prog_r)
        P_IDLE: begin
          if (prog_start) begin
            busy_r <= 1'b1; // R14
            idx_r  <= 8'h00;
            page_r <= addr_r[ARRAY_AW-1:8]; // R9
            prog_r <= P_SCAN;
          end
        end
        P_SCAN: begin
          if (advance) begin
            idx_r <= idx_r + 8'h01;
            if (idx_r == PAGE_LAST) begin
              prog_r <= P_WAIT;
            end
          end
        end
        P_WAIT: begin
          // Ready only once time elapsed and every byte reached the array
          if (timer_r == '0 && !fifo_out_valid && !wr_valid_r) begin
            busy_r <= 1'b0; // R21
            prog_r <= P_IDLE;
          end
        end
        default: prog_r <= P_IDLE;
      endcase
    end
  end

  // Self-timed duration, shorter for a single byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_r <= '0;
    end else if (prog_start) begin
      timer_r <= (count_r == 9'h001) ? TIMER_W'(BYTE_PROGRAM_CYC) // R10
                                     : TIMER_W'(PAGE_PROGRAM_CYC);
    end else if (timer_r != '0) begin
      timer_r <= timer_r - 1'b1;
    end
  end

  // Error flag; a failure report wins over the clear at a new start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (program_fail && busy_r) begin
      err_r <= 1'b1; // R16
    end else if (prog_start) begin
      err_r <= 1'b0;
    end
  end

  // Byte writes queue here so a slow array stalls the scan
  sync_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({page_r, idx_r, buf_r[idx_r]}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !wr_valid_r || array_wr_ready;

  // Registered array write port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_valid_r <= 1'b0;
      wr_word_r  <= '0;
    end else if (fifo_out_ready) begin
      wr_valid_r <= fifo_out_valid;
      wr_word_r  <= fifo_out_data;
    end
  end

  // Dual-output read: two bits per falling edge, MSB on the upper pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr_r   <= '0;
      pair_r      <= 2'h0;
      out_shift_r <= 8'h00;
      so_r        <= 1'b0;
      sio_r       <= 1'b0;
      oe_r        <= 1'b0;
    end else if (cs_hi) begin
      oe_r   <= 1'b0; // R2
      pair_r <= 2'h0;
    end else if (byte_done && state_r == ST_ADDR && hdr_cnt_r == ADDR_LAST && is_read_r) begin
      rd_addr_r <= {addr_r[13:0], shift_nxt};
    end else if (sck_fall && state_r == ST_READ) begin
      oe_r   <= 1'b1; // R19
      pair_r <= pair_r + 2'h1;
      if (pair_r == 2'h0) begin
        so_r        <= read_data[7];
        sio_r       <= read_data[6];
        out_shift_r <= {read_data[5:0], 2'b00};
        // Counter rolls from top to zero with no gap
        rd_addr_r   <= rd_addr_r + 1'b1; // R1 R20
      end else begin
        so_r        <= out_shift_r[7];
        sio_r       <= out_shift_r[6];
        out_shift_r <= {out_shift_r[5:0], 2'b00};
      end
    end
  end

  // Outputs, all from flip-flops
  assign dual_in_upper_pin_out    = so_r;
  assign dual_in_upper_pin_oe     = oe_r;
  assign second_io_pin_out        = sio_r;
  assign second_io_pin_oe         = oe_r;
  assign read_addr                = rd_addr_r;
  assign array_wr_valid           = wr_valid_r;
  assign array_wr_addr            = wr_word_r[FIFO_W-1:8];
  assign array_wr_data            = wr_word_r[7:0];
  assign write_enable_latch       = wel_r;
  assign busy                     = busy_r;
  assign program_erase_error_flag = err_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence begin_prog;
    prog_start;
  endsequence

  sequence dummy_done;
    byte_done && state_r == ST_DUMMY;
  endsequence

  // First falling edge of the read phase, pins not yet driven
  sequence first_fall;
    sck_fall && state_r == ST_READ && !oe_r;
  endsequence

  cs_hiz_a: assert property (cs_hi |=> !oe_r) // R2
    else $error("read pins driven after chip select rose");
  latch_needed_a: assert property (prog_start |-> wel_r) // R3
    else $error("program started without write enable latch");
  abort_clear_a: assert property (prog_abort |=> !wel_r && !busy_r) // R13
    else $error("abort left latch set or started busy");
  busy_set_a: assert property (begin_prog |=> busy_r && !wel_r) // R14
    else $error("busy not set or latch not cleared at start");
  busy_min_a: assert property (begin_prog |=> busy_r [*8]) // R10
    else $error("program shorter than minimum time");
  busy_hold_a: assert property (busy_r && timer_r != '0 |=> busy_r) // R21
    else $error("busy dropped before program time elapsed");
  err_set_a: assert property (program_fail && busy_r |=> err_r) // R16
    else $error("program failure not flagged");
  count_cap_a: assert property (count_r <= PAGE_FULL) // R6
    else $error("byte count above one page");
  addr_wrap_a: assert property (sck_fall && state_r == ST_READ && pair_r == 2'h0 // R20
    && rd_addr_r == ARRAY_TOP |=> rd_addr_r == '0)
    else $error("read address did not wrap to zero");
  read_begin_a: assert property (dummy_done |=> state_r == ST_READ && !oe_r) // R19
    else $error("read phase not entered after dummy byte");
  read_first_a: assert property (first_fall |=> oe_r && pair_r == 2'h1) // R19
    else $error("dual output did not start at first falling edge");

endmodule
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// Host SPI controller model: chip select, mode 0 serial clock, data pins.
// Assumes a 4 ns core clock; a serial period is 2*HALF core cycles.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic clock,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_in,
  output logic      upper_drv,
  output logic      upper_oe,
  input  wire logic upper_pin,
  input  wire logic second_pin
);
  localparam int HALF = 10; // 80 ns serial period

  // Idle: deselected, clock low, host off the shared pin
  initial begin
    chip_select_n = 1'b1;
    serial_clock  = 1'b0;
    serial_in     = 1'b0;
    upper_drv     = 1'b0;
    upper_oe      = 1'b0;
  end

  task automatic half();
    repeat (HALF) @(posedge clock);
  endtask

  // One serial clock: data set while low, pins sampled at the rise
  task automatic tick(input logic hi, input logic lo, output logic [1:0] got);
    serial_clock <= 1'b0;
    upper_drv    <= hi;
    serial_in    <= lo;
    half();
    got = {upper_pin, second_pin};
    serial_clock <= 1'b1;
    half();
  endtask

  // Byte out, MSB first; dual puts the upper bit of each pair on the shared pin
  task automatic send_byte(input logic [7:0] b, input logic dual);
    logic [1:0] g;
    upper_oe <= dual;
    if (dual) begin
      for (int i = 7; i > 0; i -= 2) tick(b[i], b[i-1], g);
    end else begin
      for (int i = 7; i >= 0; i--) tick(b[i], b[i], g);
    end
  endtask

  // Four clocks per byte on a dual read, upper pin carries the MSB
  task automatic read_byte(output logic [7:0] b);
    logic [1:0] g;
    upper_oe <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      tick(1'b0, 1'b0, g);
      b = {b[5:0], g};
    end
  endtask

  task automatic frame_begin();
    chip_select_n <= 1'b0;
    half();
  endtask

  // Release everything; data line flips so a stale level is not trusted
  task automatic frame_end();
    serial_clock <= 1'b0;
    half();
    chip_select_n <= 1'b1;
    upper_oe      <= 1'b0;
    serial_in     <= ~serial_in;
    half();
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the flash program/read sequencer.
// Assumes the host model file and the rtl package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import flash_prog_pkg::*;
  logic                clock, rst, flt;
  logic                cs_n, sck, si, h_drv, h_oe;
  logic                u_out, u_oe, s_out, s_oe;
  logic                write_enable_set, array_wr_ready, program_fail;
  logic [SECTORS-1:0]  protect_map, lockdown_map;
  logic [ARRAY_AW-1:0] read_addr, array_wr_addr;
  logic [7:0]          read_data, array_wr_data, rb;
  logic                array_wr_valid, write_enable_latch, busy, err_flag;
  logic                u_pin, s_pin;
  logic [1:0]          g;
  logic [29:0]         wq [$];        // Array writes seen
  logic [7:0]          dq [0:299];    // Data bytes sent
  int                  err_count, samples_checked, seed;

  // Undriven pins toggle so a stale value never passes
  assign u_pin = u_oe ? u_out : (h_oe ? h_drv : flt);
  assign s_pin = s_oe ? s_out : flt;

  flash_prog_seq uut (.clock(clock), .rst(rst), .chip_select_n(cs_n), .serial_clock(sck),
    .serial_in(si), .dual_in_upper_pin_in(u_pin), .dual_in_upper_pin_out(u_out),
    .dual_in_upper_pin_oe(u_oe), .second_io_pin_out(s_out), .second_io_pin_oe(s_oe),
    .write_enable_set(write_enable_set), .protect_map(protect_map),
    .lockdown_map(lockdown_map), .read_addr(read_addr), .read_data(read_data),
    .array_wr_valid(array_wr_valid), .array_wr_ready(array_wr_ready),
    .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
    .program_fail(program_fail), .write_enable_latch(write_enable_latch), .busy(busy),
    .program_erase_error_flag(err_flag));
  spi_host_model host (.clock(clock), .chip_select_n(cs_n), .serial_clock(sck),
    .serial_in(si), .upper_drv(h_drv), .upper_oe(h_oe), .upper_pin(u_pin), .second_pin(s_pin));

  // Array content is a fixed pattern of the address
  function automatic logic [7:0] rd_f(input logic [21:0] a);
    return a[7:0] ^ a[21:14] ^ 8'h3C;
  endfunction

  always #2 clock = ~clock;

  // Array model: one-cycle read, randomly stalling write side
  always @(posedge clock) begin
    flt            <= ~flt;
    read_data      <= rd_f(read_addr);
    array_wr_ready <= 1'($random(seed));
    if (array_wr_valid && array_wr_ready) wq.push_back({array_wr_addr, array_wr_data});
  end

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wel_pulse();
    write_enable_set <= 1'b1;
    @(posedge clock);
    write_enable_set <= 1'b0;
    @(posedge clock);
    `CHK(write_enable_latch, 1'b1)
  endtask

  // One program frame; tail adds stray bits, ok says whether it must run
  task automatic do_prog(input logic [7:0] op, input logic [21:0] a, input int n,
                         input logic dual, input int tail, input logic we, input logic ok);
    logic [7:0] e [0:255];
    logic       v [0:255];
    int         cyc;
    int         j;
    wq.delete();
    for (int i = 0; i < 256; i++) v[i] = 1'b0;
    if (we) wel_pulse();
    host.frame_begin();
    host.send_byte(op, 1'b0);
    for (int i = 2; i >= 0; i--) host.send_byte(8'(a >> (8 * i)), 1'b0);
    for (int k = 0; k < n; k++) begin
      dq[k] = 8'($random(seed));
      host.send_byte(dq[k], dual);
    end
    for (int k = 0; k < tail; k++) host.tick(1'b1, 1'b1, g);
    host.frame_end();
    cyc = 0;
    if (ok) `CHK(busy, 1'b1)
    while (busy === 1'b1 && cyc < 5000) begin
      @(posedge clock);
      cyc++;
    end
    `CHK(busy, 1'b0)
    `CHK(write_enable_latch, 1'b0)
    if (!ok) begin
      `CHK(cyc, 0)
      `CHK(wq.size(), 0)
    end else begin
      `CHK(cyc >= ((n == 1) ? BYTE_PROGRAM_CYC : PAGE_PROGRAM_CYC) - 12, 1'b1)
      if (n == 1) `CHK(cyc < PAGE_PROGRAM_CYC - 12, 1'b1)
      // Later bytes overwrite earlier ones at the same page index
      for (int k = 0; k < n; k++) begin
        e[8'(a[7:0] + k)] = dq[k];
        v[8'(a[7:0] + k)] = 1'b1;
      end
      j = 0;
      for (int i = 0; i < 256; i++) begin
        if (v[i]) begin
          `CHK(wq[j], {a[21:8], 8'(i), e[i]})
          j++;
        end
      end
      `CHK(wq.size(), j)
    end
  endtask

  // Hang guard; a clean run needs about 40k cycles
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    summarize();
  end

  // Main sequence
  initial begin
    clock = 1'b0;
    flt = 1'b0;
    rst = 1'b1;
    seed = 32'hdf6c00a6;
    err_count = 0;
    samples_checked = 0;
    write_enable_set = 1'b0;
    array_wr_ready = 1'b0;
    program_fail = 1'b0;
    read_data = 8'h00;
    protect_map = 64'h0000000000000020;
    lockdown_map = 64'h0000000000000200;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    `CHK({busy, write_enable_latch}, 2'h0)
    // Dual read across the array top
    host.frame_begin();
    host.send_byte(OP_DUAL_READ, 1'b0);
    for (int i = 0; i < 4; i++) host.send_byte((i == 0) ? 8'h3F : ((i == 3) ? 8'h00 : 8'hFF), 1'b0);
    host.read_byte(rb);
    `CHK(rb, rd_f(ARRAY_TOP))
    host.read_byte(rb);
    `CHK(rb, rd_f(22'h000000))
    host.tick(1'b0, 1'b0, g);
    `CHK({u_oe, s_oe}, 2'h3)
    host.frame_end();
    `CHK({u_oe, s_oe}, 2'h0)
    // Programs that must run, then ones that must not
    do_prog(OP_PROGRAM, 22'h0000FE, 3, 1'b0, 0, 1'b1, 1'b1);
    do_prog(OP_DUAL_PROGRAM, 22'($random(seed)) & 22'h03FFFF, 1, 1'b1, 0, 1'b1, 1'b1);
    do_prog(OP_DUAL_PROGRAM, 22'h120000, 258, 1'b1, 0, 1'b1, 1'b1);
    do_prog(OP_PROGRAM, 22'h000100, 2, 1'b0, 0, 1'b0, 1'b0);
    do_prog(OP_PROGRAM, 22'h000200, 1, 1'b0, 3, 1'b1, 1'b0);
    do_prog(OP_PROGRAM, 22'h000300, 0, 1'b0, 0, 1'b1, 1'b0);
    do_prog(OP_DUAL_PROGRAM, 22'h050010, 2, 1'b1, 0, 1'b1, 1'b0);
    do_prog(OP_PROGRAM, 22'h09FFFF, 2, 1'b0, 0, 1'b1, 1'b0);
    // Failing byte raises the error flag; next program start clears it
    program_fail <= 1'b1;
    do_prog(OP_PROGRAM, 22'h000400, 1, 1'b0, 0, 1'b1, 1'b1);
    program_fail <= 1'b0;
    `CHK(err_flag, 1'b1)
    do_prog(OP_PROGRAM, 22'h0007FF, 2, 1'b0, 0, 1'b1, 1'b1);
    `CHK(err_flag, 1'b0)
    summarize();
  end
endmodule
`default_nettype wire
